/* File: design/fan_ctrl_pkg.sv */
package fan_ctrl_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_MAIN = 8'h00;
   localparam logic [7:0] IDX_STATUS = 8'h02;
   localparam logic [7:0] IDX_READING = 8'h08;
   localparam logic [7:0] IDX_TARGET = 8'h10;
   localparam logic [7:0] IDX_RANGE = 8'h20;
   localparam logic [7:0] IDX_DUTY = 8'h22;
   localparam logic [7:0] IDX_FILTER = 8'h23;
   localparam logic [7:0] IDX_MASK = 8'h24;

   // field positions
   localparam int MAIN_AUTO_BIT = 7;
   localparam int MAIN_RPM_BIT = 5;
   localparam int MAIN_INV_BIT = 3;
   localparam int RANGE_LSB = 6;
   localparam int RAMP_LSB = 5;
   localparam int FILTER_EN_BIT = 0;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_FAIL_BIT = 1;

   // reset values
   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam logic [7:0] TARGET_RST = 8'hFF;
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [7:0] RANGE_RST = 8'h40;
   localparam logic [7:0] FILTER_RST = 8'h10;
   localparam logic [7:0] MASK_RST = 8'h00;

   // duty and count figures
   localparam logic [7:0] SLOTS = 8'hF0;
   localparam logic [7:0] CODE_STEP = 8'h10;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] RPM_FLOOR = 8'h80;

   // timing: measurement oscillator derived from the bus clock
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 11_250;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;
   localparam int SLOT_DIV = 4;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: design/fan_tach_meter.sv */
`timescale 1ns/100ps
module fan_tach_meter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tach_in,
   input wire logic count_tick,
   output logic meas_done,
   output logic [7:0] meas_count
);
   typedef enum logic [1:0] {WAIT_FIRST, WAIT_SECOND, COUNTING} meter_state_t;

   meter_state_t state_r;
   logic s1_r, s2_r, s3_r, level_r, third_r;
   logic [7:0] cnt_r;

   // tach comes from the pin: three flops, a change counts once stages two and three agree
   wire settled = (s2_r == s3_r);
   wire rise = settled && s2_r && !level_r;
   wire sat_hit = count_tick && (cnt_r == fan_ctrl_pkg::COUNT_MAX - 8'h01);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         s1_r <= tach_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (settled) begin
            level_r <= s2_r;
         end
      end
   end

   // count from the second rising edge to the fourth, saturating at full scale
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= WAIT_FIRST;
         cnt_r <= 8'h00;
         third_r <= 1'b0;
         meas_done <= 1'b0;
         meas_count <= 8'h00;
      end else begin
         meas_done <= 1'b0;
         case (state_r)
            WAIT_FIRST: begin
               if (rise) begin
                  state_r <= WAIT_SECOND;
               end
            end
            WAIT_SECOND: begin
               if (rise) begin
                  state_r <= COUNTING;
                  cnt_r <= 8'h00;
                  third_r <= 1'b0;
               end
            end
            COUNTING: begin
               if (sat_hit) begin
                  meas_done <= 1'b1;
                  meas_count <= fan_ctrl_pkg::COUNT_MAX;
                  state_r <= WAIT_FIRST;
               end else if (rise && third_r) begin
                  meas_done <= 1'b1;
                  meas_count <= cnt_r;
                  state_r <= WAIT_FIRST;
               end else begin
                  if (rise) begin
                     third_r <= 1'b1;
                  end
                  if (count_tick) begin
                     cnt_r <= cnt_r + 8'h01;
                  end
               end
            end
            default: state_r <= WAIT_FIRST;
         endcase
      end
   end

   saturate_report_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == COUNTING) && sat_hit |=> meas_done && (meas_count == 8'hFF))
      else $error("saturated count not reported as full scale");
endmodule

/* File: design/fan_speed_mode_control.sv */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module fan_speed_mode_control #(
   parameter int OSC_DIV = fan_ctrl_pkg::OSC_DIV,
   parameter int SLOT_DIV = fan_ctrl_pkg::SLOT_DIV
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic tach_in,
   input wire logic [7:0] auto_duty_slots,
   output logic pwm_out,
   output logic irq,
   output logic fan_fail
);
   // registers
   logic [7:0] main_configuration_r, speed_target_count_r, fixed_duty_setting_r;
   logic [7:0] speed_range_r, fan_filter_r, irq_mask_r, irq_status_r, speed_reading_r;
   logic [7:0] irq_status_nxt, duty_r, duty_nxt, slot_r;
   logic wr_pend_r;
   logic [7:0] wr_idx_r;
   logic [15:0] osc_cnt_r;
   logic [7:0] slot_div_r;
   logic [2:0] range_cnt_r;
   logic meas_done;
   logic [7:0] meas_count;

   // oscillator divider width covers the long count with room
   function automatic logic [2:0] range_mask(input logic [1:0] code);
      case (code)
         2'h0: range_mask = 3'h0;
         2'h1: range_mask = 3'h1;
         2'h2: range_mask = 3'h3;
         default: range_mask = 3'h7;
      endcase
   endfunction

   // move cur toward tgt by at most step, never past it
   function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt,
                                              input logic [7:0] step);
      if (tgt > cur) begin
         step_toward = (tgt - cur > step) ? cur + step : tgt;
      end else begin
         step_toward = (cur - tgt > step) ? cur - step : tgt;
      end
   endfunction

   // address phase decode; anything off the map reads zero and swallows writes
   wire accept = hsel && hready && htrans[1];
   wire [7:0] a_idx = haddr[9:2];
   wire a_mapped = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
   wire rd_accept = accept && !hwrite;
   wire wr_accept = accept && hwrite && a_mapped;
   wire status_rd = rd_accept && a_mapped && (a_idx == fan_ctrl_pkg::IDX_STATUS);

   // read mux
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (a_mapped) begin
         case (a_idx)
            fan_ctrl_pkg::IDX_MAIN: rd_mux = main_configuration_r;
            fan_ctrl_pkg::IDX_STATUS: rd_mux = irq_status_r;
            fan_ctrl_pkg::IDX_READING: rd_mux = speed_reading_r;
            fan_ctrl_pkg::IDX_TARGET: rd_mux = speed_target_count_r;
            fan_ctrl_pkg::IDX_RANGE: rd_mux = speed_range_r;
            fan_ctrl_pkg::IDX_DUTY: rd_mux = fixed_duty_setting_r;
            fan_ctrl_pkg::IDX_FILTER: rd_mux = fan_filter_r;
            fan_ctrl_pkg::IDX_MASK: rd_mux = irq_mask_r;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // data phase write strobes
   wire wr_main = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_MAIN);
   wire wr_target = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_TARGET);
   wire wr_range = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_RANGE);
   wire wr_duty = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_DUTY);
   wire wr_filter = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_FILTER);
   wire wr_mask = wr_pend_r && (wr_idx_r == fan_ctrl_pkg::IDX_MASK);
   // irq looks at the mask as it will stand, so a mask write lands in step with status
   wire [7:0] mask_nxt = wr_mask ? hwdata[7:0] : irq_mask_r;

   // zero wait slave: read data registered at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_idx_r <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= wr_accept;
         wr_idx_r <= a_idx;
         if (rd_accept) begin
            hrdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // software registers; the target is a plain 8-bit period count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_configuration_r <= fan_ctrl_pkg::MAIN_RST;
         speed_target_count_r <= fan_ctrl_pkg::TARGET_RST;
         fixed_duty_setting_r <= fan_ctrl_pkg::DUTY_RST;
         speed_range_r <= fan_ctrl_pkg::RANGE_RST;
         fan_filter_r <= fan_ctrl_pkg::FILTER_RST;
         irq_mask_r <= fan_ctrl_pkg::MASK_RST;
      end else begin
         if (wr_main) main_configuration_r <= hwdata[7:0];
         if (wr_target) speed_target_count_r <= hwdata[7:0];
         if (wr_range) speed_range_r <= hwdata[7:0];
         if (wr_duty) fixed_duty_setting_r <= hwdata[7:0];
         if (wr_filter) fan_filter_r <= hwdata[7:0];
         if (wr_mask) irq_mask_r <= hwdata[7:0];
      end
   end

   // mode decode
   wire auto_mode = main_configuration_r[fan_ctrl_pkg::MAIN_AUTO_BIT];
   wire rpm_mode = !auto_mode && main_configuration_r[fan_ctrl_pkg::MAIN_RPM_BIT];
   wire fixed_mode = !auto_mode && !rpm_mode;
   wire invert = main_configuration_r[fan_ctrl_pkg::MAIN_INV_BIT];
   wire filter_en = fan_filter_r[fan_ctrl_pkg::FILTER_EN_BIT];
   wire [1:0] range_code = speed_range_r[fan_ctrl_pkg::RANGE_LSB +: 2];
   wire [1:0] ramp_code = fan_filter_r[fan_ctrl_pkg::RAMP_LSB +: 2];
   wire [7:0] ramp_step = 8'h01 << ramp_code;

   // code n maps to n*16 of 240 slots, so 0F is exactly full on
   wire [7:0] fixed_slots = {fixed_duty_setting_r[3:0], 4'h0};
   wire [7:0] auto_slots = (auto_duty_slots > fan_ctrl_pkg::SLOTS) ?
                           fan_ctrl_pkg::SLOTS : auto_duty_slots;

   // oscillator and speed range prescaler feeding the period counter
   wire osc_tick = (osc_cnt_r == 16'(OSC_DIV - 1));
   wire meas_tick = osc_tick && ((range_cnt_r & range_mask(range_code)) == 3'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt_r <= 16'h0000;
         range_cnt_r <= 3'h0;
      end else begin
         osc_cnt_r <= osc_tick ? 16'h0000 : osc_cnt_r + 16'h0001;
         if (osc_tick) begin
            range_cnt_r <= range_cnt_r + 3'h1;
         end
      end
   end

   fan_tach_meter i_fan_tach_meter (
      .hclk(hclk),
      .hresetn(hresetn),
      .tach_in(tach_in),
      .count_tick(meas_tick),
      .meas_done(meas_done),
      .meas_count(meas_count)
   );

   // pwm slot counter, 240 slots per period
   wire slot_tick = (slot_div_r == 8'(SLOT_DIV - 1));
   wire period_end = slot_tick && (slot_r == fan_ctrl_pkg::SLOTS - 8'h01);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_div_r <= 8'h00;
         slot_r <= 8'h00;
      end else begin
         slot_div_r <= slot_tick ? 8'h00 : slot_div_r + 8'h01;
         if (slot_tick) begin
            slot_r <= period_end ? 8'h00 : slot_r + 8'h01;
         end
      end
   end

   // closed loop compares the measured period with the target count
   wire too_slow = meas_count > speed_target_count_r;
   wire too_fast = meas_count < speed_target_count_r;
   wire at_max = (meas_count == fan_ctrl_pkg::COUNT_MAX);
   // only the top of the range is regulated; lower duty gives no usable tach
   wire can_drop = duty_r > fan_ctrl_pkg::RPM_FLOOR;

   // duty selection per mode; filtered auto ramps once per pwm period
   always_comb begin
      duty_nxt = duty_r;
      if (auto_mode) begin
         if (!filter_en) begin
            duty_nxt = auto_slots;
         end else if (period_end) begin
            duty_nxt = step_toward(duty_r, auto_slots, ramp_step);
         end
      end else if (rpm_mode) begin
         if (meas_done && too_slow && duty_r < fan_ctrl_pkg::SLOTS) begin
            duty_nxt = duty_r + 8'h01;
         end else if (meas_done && too_fast && can_drop) begin
            duty_nxt = duty_r - 8'h01;
         end
      end else begin
         duty_nxt = fixed_slots;
      end
   end

   // fault: closed loop knows only full scale, other modes also the limit
   wire underspeed = rpm_mode ? at_max : (at_max || too_slow);

   // sticky status, cleared by reading it; a new event beats the clear
   always_comb begin
      irq_status_nxt = status_rd ? 8'h00 : irq_status_r;
      if (meas_done) begin
         irq_status_nxt[fan_ctrl_pkg::STAT_DONE_BIT] = 1'b1;
         if (underspeed) begin
            irq_status_nxt[fan_ctrl_pkg::STAT_FAIL_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_r <= 8'h00;
         pwm_out <= 1'b0;
         irq_status_r <= 8'h00;
         irq <= 1'b0;
         fan_fail <= 1'b0;
         speed_reading_r <= 8'h00;
      end else begin
         duty_r <= duty_nxt;
         pwm_out <= (slot_r < duty_r) ^ invert;
         irq_status_r <= irq_status_nxt;
         irq <= |(irq_status_nxt & mask_nxt);
         if (meas_done) begin
            speed_reading_r <= meas_count;
            fan_fail <= underspeed;
         end
      end
   end

   fixed_duty_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fixed_mode |=> duty_r == $past(fixed_slots))
      else $error("fixed mode duty does not follow the register");

   full_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fixed_mode && (fixed_duty_setting_r[3:0] == 4'hF) |=> ##1 pwm_out == !$past(invert))
      else $error("code 0F does not give full duty");

   auto_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
      auto_mode && !filter_en |=> duty_r == $past(auto_slots))
      else $error("unfiltered auto duty does not follow the input");

   rpm_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rpm_mode && meas_done && too_slow && (duty_r < 8'hF0) |=> duty_r == $past(duty_r) + 8'h01)
      else $error("slow fan did not raise the drive");

   rpm_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rpm_mode && meas_done && too_fast && (duty_r > 8'h80) |=> duty_r == $past(duty_r) - 8'h01)
      else $error("fast fan did not lower the drive");

   rpm_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rpm_mode && !meas_done |=> $stable(duty_r))
      else $error("closed loop duty moved without a measurement");

   rpm_nofail_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rpm_mode && meas_done && !at_max |=> !fan_fail)
      else $error("closed loop flagged failure below full scale");

   max_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
      meas_done && at_max |=> fan_fail && irq_status_r[1])
      else $error("full scale count did not mark the fan failing");

   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == |(irq_status_r & irq_mask_r))
      else $error("interrupt does not match masked status");

   // duty limits, filter ramp, target write and status bookkeeping
   pwm_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fixed_mode && (fixed_duty_setting_r[3:0] == 4'h0) |=> ##1 pwm_out == $past(invert))
      else $error("code 00 does not give zero duty");

   rpm_floor_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rpm_mode && meas_done && too_fast && (duty_r <= 8'h80) |=> $stable(duty_r))
      else $error("closed loop drove the duty below its floor");

   ramp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      auto_mode && filter_en && !period_end |=> $stable(duty_r))
      else $error("filtered duty moved inside a pwm period");

   filter_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      auto_mode && filter_en && period_end && (auto_slots > duty_r) |=> duty_r > $past(duty_r))
      else $error("filtered duty did not ramp toward a higher demand");

   target_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_target |=> speed_target_count_r == $past(hwdata[7:0]))
      else $error("target count write did not land");

   fail_stand_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !meas_done |=> $stable(fan_fail))
      else $error("fan failure changed without a measurement");

   reading_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
      meas_done |=> speed_reading_r == $past(meas_count))
      else $error("speed reading did not take the finished count");

   status_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      meas_done |=> irq_status_r[fan_ctrl_pkg::STAT_DONE_BIT])
      else $error("measurement done did not set its status bit");

   status_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_status_r[fan_ctrl_pkg::STAT_DONE_BIT] && !status_rd
      |=> irq_status_r[fan_ctrl_pkg::STAT_DONE_BIT])
      else $error("done status dropped without a read");

   status_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      status_rd && !meas_done |=> irq_status_r == 8'h00)
      else $error("status read did not clear the status");

   irq_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      status_rd && !meas_done |=> !irq)
      else $error("interrupt stayed up after the status read");
endmodule

/* File: tb/fan_model.sv */
`timescale 1ns/100ps
// fan stand-in: tach toggles every half_clk clocks, stays low (stalled) while half_clk is zero
module fan_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [15:0] half_clk,
   output logic tach_in
);
   logic [15:0] cnt_r;
   // speed is commanded by the bench; rotor inertia is not modelled, so a change is immediate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 16'h0000;
         tach_in <= 1'b0;
      end else if (half_clk == 16'h0000) begin
         cnt_r <= 16'h0000;
         tach_in <= 1'b0;
      end else if (cnt_r >= half_clk - 16'h0001) begin
         cnt_r <= 16'h0000;
         tach_in <= ~tach_in; // two pulses a turn assumed
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule

/* File: tb/fan_speed_mode_control_tb.sv */
`timescale 1ns/100ps
module fan_speed_mode_control_tb;
   logic hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, q, s;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] auto_duty_slots;
   logic [15:0] half_clk;
   logic hreadyout, hresp, pwm_out, irq, fan_fail, tach_in;
   logic [31:0] hrdata;
   int err_total, checks_done, cycles, h1, h2;

   // small dividers keep each tach measurement to about two thousand clocks
   fan_speed_mode_control #(.OSC_DIV(8), .SLOT_DIV(1)) i_fan_speed_mode_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tach_in(tach_in),
      .auto_duty_slots(auto_duty_slots), .pwm_out(pwm_out), .irq(irq), .fan_fail(fan_fail));
   fan_model i_fan_model (.hclk(hclk), .hresetn(hresetn), .half_clk(half_clk), .tach_in(tach_in));

   function automatic logic [31:0] ra(input logic [7:0] idx);
      return {22'h00_0000, idx, 2'h0};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one single transfer: address phase held until hready, then data phase until hready
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= ra(idx);
      hwrite <= wr;
      htrans <= fan_ctrl_pkg::HTRANS_NONSEQ;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      check(hresp, 1'b0);
   endtask

   // high clocks over one whole pwm period after a settle delay, sampled where pwm_out is settled
   task automatic highs(input int settle, output int h);
      repeat (settle) @(posedge hclk);
      h = 0;
      repeat (240) begin
         @(negedge hclk);
         if (pwm_out === 1'b1) h++;
      end
   endtask

   // clear status, wait for the next measurement done, return status read then
   task automatic wait_meas;
      int n;
      n = 0;
      bus(1'b0, fan_ctrl_pkg::IDX_STATUS, 32'h0000_0000);
      do begin
         @(posedge hclk);
         n++;
      end while (irq !== 1'b1 && n < 12000);
      check(irq, 1'b1); // a measurement that never comes counts as a mismatch
      bus(1'b0, fan_ctrl_pkg::IDX_STATUS, 32'h0000_0000);
      s = q;
   endtask

   task automatic t_reset;
      logic [7:0] ix [9] = '{8'h00, 8'h02, 8'h08, 8'h10, 8'h20, 8'h22, 8'h23, 8'h24, 8'h3F};
      logic [7:0] ex [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h40, 8'h00, 8'h10, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, ix[i], 32'h0000_0000);
         check(q, {24'h00_0000, ex[i]});
      end
      check(hreadyout, 1'b1);
   endtask

   // temperature input is set high to show that software mode ignores it
   task automatic t_fixed;
      logic [3:0] codes [3] = '{4'h0, 4'h8, 4'hF};
      auto_duty_slots <= 8'd200;
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, fan_ctrl_pkg::IDX_DUTY, {28'h000_0000, codes[i]});
         highs(244, h1);
         check(h1, codes[i] * 16);
      end
      bus(1'b1, fan_ctrl_pkg::IDX_DUTY, 32'h0000_0000);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0008);
      highs(244, h1);
      check(h1, 240);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0080);
      auto_duty_slots <= 8'd60;
      highs(244, h1);
      check(h1, 60);
      // filtered: ramp 8 slots a period from zero up to a demand of 100
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0000);
      bus(1'b1, fan_ctrl_pkg::IDX_FILTER, 32'h0000_0061);
      auto_duty_slots <= 8'h64;
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0080);
      highs(244, h1);
      check(h1 > 0 && h1 < 60, 1'b1);
      highs(3500, h2);
      check(h2, 100);
      bus(1'b1, fan_ctrl_pkg::IDX_FILTER, 32'h0000_0010);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0000);
   endtask

   // count = 2 tach periods of 400 clocks over ticks of 16 clocks, about 50
   task automatic t_meas;
      bus(1'b1, fan_ctrl_pkg::IDX_RANGE, 32'h0000_0040);
      bus(1'b1, fan_ctrl_pkg::IDX_MASK, 32'h0000_0001);
      half_clk <= 16'd200;
      wait_meas;
      wait_meas;
      check(s[fan_ctrl_pkg::STAT_DONE_BIT], 1'b1);
      bus(1'b0, fan_ctrl_pkg::IDX_READING, 32'h0000_0000);
      check(q >= 49 && q <= 51, 1'b1);
      check(fan_fail, 1'b0);
      repeat (2) @(posedge hclk);
      check(irq, 1'b0);
      bus(1'b1, fan_ctrl_pkg::IDX_MASK, 32'h0000_0000);
      repeat (2500) @(posedge hclk);
      check(irq, 1'b0);
      bus(1'b0, fan_ctrl_pkg::IDX_STATUS, 32'h0000_0000);
      check(q[fan_ctrl_pkg::STAT_DONE_BIT], 1'b1);
      bus(1'b1, fan_ctrl_pkg::IDX_MASK, 32'h0000_0001);
   endtask

   // a 2400-clock period overruns the counter; then count 50 against target 30
   task automatic t_fail;
      half_clk <= 16'd1200;
      wait_meas;
      wait_meas;
      check(s[fan_ctrl_pkg::STAT_FAIL_BIT], 1'b1);
      check(fan_fail, 1'b1);
      bus(1'b0, fan_ctrl_pkg::IDX_READING, 32'h0000_0000);
      check(q, 32'h0000_00FF);
      bus(1'b1, fan_ctrl_pkg::IDX_TARGET, 32'h0000_001E);
      half_clk <= 16'd200;
      wait_meas;
      wait_meas;
      check(fan_fail, 1'b1);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0020);
      wait_meas;
      wait_meas;
      check(fan_fail, 1'b0);
   endtask

   // start at code 0A, well above the loop floor, target count 40
   task automatic t_rpm;
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0000);
      bus(1'b1, fan_ctrl_pkg::IDX_DUTY, 32'h0000_000A);
      bus(1'b1, fan_ctrl_pkg::IDX_TARGET, 32'h0000_0028);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0020);
      wait_meas;
      highs(4, h1);
      wait_meas;
      highs(4, h2);
      check(h2, h1 + 1);
      half_clk <= 16'd100;
      wait_meas;
      wait_meas;
      highs(4, h1);
      wait_meas;
      highs(4, h2);
      check(h2, h1 - 1);
      // a fast fan at code 08 must not pull the drive below the regulated range
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0000);
      bus(1'b1, fan_ctrl_pkg::IDX_DUTY, 32'h0000_0008);
      bus(1'b1, fan_ctrl_pkg::IDX_MAIN, 32'h0000_0020);
      wait_meas;
      wait_meas;
      highs(4, h1);
      check(h1, 128);
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ceiling sits well above the expected run of about forty thousand clocks
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 95000) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      auto_duty_slots = 8'h00;
      half_clk = 16'h0000;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_fixed();
      t_meas();
      t_fail();
      t_rpm();
      finish_test();
   end
endmodule
